// ===== hdl/hbc_defs.svh
// Constants for the host bridge command and identifier register bank.
// Included by hbc_pkg and by the bank; definitions only.
`ifndef HBC_DEFS_SVH
`define HBC_DEFS_SVH

`define HBC_OFF_FUNC_ID     8'h02
`define HBC_OFF_COMMAND     8'h04
`define HBC_OFF_STATUS      8'h06
`define HBC_CMD_RESET       16'h0006
`define HBC_CMD_RO_MASK     16'hFEFF
`define HBC_BIT_SERR_EN     8
`define HBC_BIT_MASTER_EN   2
`define HBC_BIT_MEM_EN      1
`define HBC_STS_BASE        16'h0090
`define HBC_BIT_SIG_SERR    14
`define HBC_FUNC_ID_DEFAULT 16'h5A5A

`endif

// ===== hdl/hbc_pkg.sv
// Types for the host bridge command and identifier register bank.
// Assumes hbc_defs.svh is on the include path.
`include "hbc_defs.svh"

package hbc_pkg;
   typedef logic [15:0] hbc_word_t;
   typedef logic [7:0]  hbc_addr_t;
   typedef logic [3:0]  hbc_err_t;
endpackage

// ===== hdl/hbc_regs.sv
// Configuration registers of bridge function 0: identifier, command,
// signalled system-error status, and system-error message request.
// Assumes a config port with one-cycle read/write strobes on mclk.
//
// How it works
// - Fixed read-only function identifier value
// - Command register at 04h, resets 0006h
// - Bit 9 back-to-back enable reads zero
// - Bit 8 read/write system error enable
// - Enabled errors send hub link message
// - Error signalled only by hub message
// - Own enable ORed with function 1's
// - Error reported in error and PCI status
// - Bits 7,6,5 hardwired zero
// - Bit 4 zero, no write-invalidate
// - Bits 3 and 0 hardwired zero
// - Bit 2 hardwired one, master enabled
// - Bit 1 hardwired one, memory enabled
// - Bits 15:10 reserved read-only
// - Status bit 14 set, write-one clears
`timescale 1ns/1ps
`default_nettype none
`include "hbc_defs.svh"

module hbc_regs #(
   parameter hbc_pkg::hbc_word_t FUNC_ID = `HBC_FUNC_ID_DEFAULT, // Arbitrary value
   parameter int                 ERR_W   = 4
) (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire hbc_pkg::hbc_addr_t cfg_addr,
   input  wire logic               cfg_rd,
   input  wire logic               cfg_wr,
   input  wire hbc_pkg::hbc_word_t cfg_wdata,
   output var  hbc_pkg::hbc_word_t cfg_rdata,
   input  wire logic [ERR_W-1:0]   error_event,
   input  wire logic [ERR_W-1:0]   error_command,
   input  wire logic               func1_serr_enable,
   input  wire logic               func1_serr_event,
   input  wire logic               hub_msg_ready,
   output var  logic               hub_link_serr_msg,
   output var  logic               serr_reported,
   output var  logic               master_enable,
   output var  logic               memory_space_enable,
   output var  logic               hub_serr_active
);
   import hbc_pkg::*;

   //------------------------------------------------------------
   // Constant images
   //------------------------------------------------------------
   localparam int        WORD_W    = $bits(hbc_word_t);
   localparam hbc_word_t CMD_RESET = `HBC_CMD_RESET;
   localparam hbc_word_t CMD_RO    = `HBC_CMD_RO_MASK;
   localparam hbc_word_t CMD_FIXED = CMD_RESET & CMD_RO;
   localparam hbc_word_t STS_FIXED = `HBC_STS_BASE;
   localparam hbc_word_t WORD_ZERO = 16'h0000;

   //------------------------------------------------------------
   // Signals
   //------------------------------------------------------------
   // Decode
   logic           hit_func_id;
   logic           hit_command;
   logic           hit_status;
   logic           cmd_wr;
   logic           sts_clr;
   // State
   logic           serr_en_reg;
   logic           sig_serr_reg;
   logic           msg_pend_reg;
   // Error paths
   logic           own_err;
   logic           func1_err;
   logic           any_err;
   // Read images
   wire hbc_word_t cmd_view;
   wire hbc_word_t sts_view;

   //------------------------------------------------------------
   // Access decode
   //------------------------------------------------------------
   assign hit_func_id = cfg_addr == `HBC_OFF_FUNC_ID;
   assign hit_command = cfg_addr == `HBC_OFF_COMMAND;
   assign hit_status  = cfg_addr == `HBC_OFF_STATUS;
   // Writes elsewhere fall on nothing
   assign cmd_wr      = cfg_wr && hit_command;
   assign sts_clr     = cfg_wr && hit_status && cfg_wdata[`HBC_BIT_SIG_SERR];

   //------------------------------------------------------------
   // Command register
   //------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         serr_en_reg <= CMD_RESET[`HBC_BIT_SERR_EN];
      end else if (cmd_wr) begin
         serr_en_reg <= cfg_wdata[`HBC_BIT_SERR_EN];
      end
   end

   //------------------------------------------------------------
   // Error sources
   //------------------------------------------------------------
   // Own errors need the global and the per-condition enable
   assign own_err   = serr_en_reg && |(error_event & error_command);
   // Function 1 errors follow only function 1's enable
   assign func1_err = func1_serr_enable && func1_serr_event;
   assign any_err   = own_err || func1_err;

   //------------------------------------------------------------
   // Hub link message request
   //------------------------------------------------------------
   // Request held until the hub link can take it; a new error wins
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msg_pend_reg <= 1'b0;
      end else if (any_err) begin
         msg_pend_reg <= 1'b1;
      end else if (hub_msg_ready) begin
         msg_pend_reg <= 1'b0;
      end
   end

   // No error pin: the message pulse is the only way out
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hub_link_serr_msg <= 1'b0;
      end else begin
         hub_link_serr_msg <= msg_pend_reg && hub_msg_ready;
      end
   end

   // Either function's enable keeps the shared path armed
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hub_serr_active <= 1'b0;
      end else begin
         hub_serr_active <= serr_en_reg || func1_serr_enable;
      end
   end

   //------------------------------------------------------------
   // Signalled system-error status
   //------------------------------------------------------------
   // Set wins over a write-one-clear in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sig_serr_reg <= 1'b0;
      end else if (own_err) begin
         sig_serr_reg <= 1'b1;
      end else if (sts_clr) begin
         sig_serr_reg <= 1'b0;
      end
   end

   // Pulse toward the error status register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         serr_reported <= 1'b0;
      end else begin
         serr_reported <= own_err;
      end
   end

   //------------------------------------------------------------
   // Fixed enables seen by the rest of the bridge
   //------------------------------------------------------------
   // Constant ones, held low through reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         master_enable <= 1'b0;
      end else begin
         master_enable <= cmd_view[`HBC_BIT_MASTER_EN];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         memory_space_enable <= 1'b0;
      end else begin
         memory_space_enable <= cmd_view[`HBC_BIT_MEM_EN];
      end
   end

   //------------------------------------------------------------
   // Read images, one bit at a time
   //------------------------------------------------------------
   // One live bit per register; the rest are constants
   for (genvar gb = 0; gb < WORD_W; gb++) begin : g_bit
      if (gb == `HBC_BIT_SERR_EN) begin : g_cmd_live
         assign cmd_view[gb] = serr_en_reg;
      end else begin : g_cmd_fixed
         assign cmd_view[gb] = CMD_FIXED[gb];
      end
      if (gb == `HBC_BIT_SIG_SERR) begin : g_sts_live
         assign sts_view[gb] = sig_serr_reg;
      end else begin : g_sts_fixed
         assign sts_view[gb] = STS_FIXED[gb];
      end
   end

   //------------------------------------------------------------
   // Read path
   //------------------------------------------------------------
   // Read data stands until the next read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_rdata <= WORD_ZERO;
      end else if (cfg_rd) begin
         if (hit_func_id) begin
            cfg_rdata <= FUNC_ID;
         end else if (hit_command) begin
            cfg_rdata <= cmd_view;
         end else if (hit_status) begin
            cfg_rdata <= sts_view;
         end else begin
            cfg_rdata <= WORD_ZERO;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/hbc_regs_sva.sv
// Port checker for hbc_regs.
// Bound to every hbc_regs instance.
`timescale 1ns/1ps
`default_nettype none
module hbc_regs_sva #(
   parameter hbc_pkg::hbc_word_t FUNC_ID = 16'h5A5A, // Arbitrary value
   parameter int ERR_W = 4
) (
   input wire logic               mclk,
   input wire logic               sys_rst,
   input wire logic               cfg_rd,
   input wire hbc_pkg::hbc_addr_t cfg_addr,
   input wire hbc_pkg::hbc_word_t cfg_rdata,
   input wire logic [ERR_W-1:0]   error_event,
   input wire logic [ERR_W-1:0]   error_command,
   input wire logic               func1_serr_enable,
   input wire logic               hub_msg_ready,
   input wire logic               hub_link_serr_msg,
   input wire logic               serr_reported,
   input wire logic               hub_serr_active,
   input wire logic               master_enable,
   input wire logic               memory_space_enable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   mst_on_a: assert property (!$past(sys_rst) |-> master_enable) else $error("master off");
   mem_on_a: assert property (!$past(sys_rst) |-> memory_space_enable) else $error("mem off");
   id_read_a: assert property (cfg_rd && cfg_addr == 8'h02 |-> ##1 cfg_rdata == FUNC_ID)
      else $error("bad id");
   cmd_fixed_a: assert property (cfg_rd && cfg_addr == 8'h04 |-> ##1
      (cfg_rdata & 16'hFEFF) == 16'h0006) else $error("bad command");
   err_cause_a: assert property (serr_reported |-> $past(|(error_event & error_command)))
      else $error("report without cause");
   no_serr_a: assert property (!hub_serr_active |-> !serr_reported) else $error("report off");
   serr_or_a: assert property (!$past(sys_rst) && $past(func1_serr_enable) |-> hub_serr_active)
      else $error("or lost");
   msg_rdy_a: assert property (hub_link_serr_msg |-> $past(hub_msg_ready)) else $error("no ready");
   cover property (hub_link_serr_msg);
   cover property (serr_reported);
   cover property (hub_serr_active && !serr_reported);
endmodule
bind hbc_regs hbc_regs_sva #(
   .FUNC_ID (FUNC_ID),
   .ERR_W   (ERR_W)
) u_sva (
   .mclk                (mclk),
   .sys_rst             (sys_rst),
   .cfg_rd              (cfg_rd),
   .cfg_addr            (cfg_addr),
   .cfg_rdata           (cfg_rdata),
   .error_event         (error_event),
   .error_command       (error_command),
   .func1_serr_enable   (func1_serr_enable),
   .hub_msg_ready       (hub_msg_ready),
   .hub_link_serr_msg   (hub_link_serr_msg),
   .serr_reported       (serr_reported),
   .hub_serr_active     (hub_serr_active),
   .master_enable       (master_enable),
   .memory_space_enable (memory_space_enable)
);
`default_nettype wire

// ===== tb/hbc_hub_model.sv
// Hub link receiver: takes messages when not stalled.
// Assumes stall changes off the rising edge.
`timescale 1ns/1ps
`default_nettype none
module hbc_hub_model (
   input  wire logic mclk,
   input  wire logic stall,
   input  wire logic msg,
   output var  logic ready,
   output var  int   msgs
);
   initial begin
      ready = 1'b0;
      msgs = 0;
      forever begin
         @(posedge mclk);
         ready <= !stall;
         if (msg) begin
            msgs <= msgs + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/hbc_regs_tb_top.sv
// Self-checking bench for hbc_regs.
// Assumes the checker and hub model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module hbc_regs_tb_top;
   import hbc_pkg::*;
   localparam hbc_word_t FUNC_ID = 16'h1234; // Arbitrary value
   localparam int ERR_W = 4;
   logic mclk = 0, sys_rst = 1, cfg_rd = 0, cfg_wr = 0, stall = 0;
   logic func1_serr_enable = 0, func1_serr_event = 0;
   hbc_addr_t cfg_addr = 8'h00;
   hbc_word_t cfg_wdata = 16'h0000, cfg_rdata;
   logic [3:0] error_event = 4'h0, error_command = 4'hF;
   logic hub_msg_ready, hub_link_serr_msg, serr_reported;
   logic master_enable, memory_space_enable, hub_serr_active;
   int msgs, errors = 0, check_count = 0;
   hbc_regs #(
      .FUNC_ID (FUNC_ID),
      .ERR_W   (ERR_W)
   ) dut (
      .mclk                (mclk),
      .sys_rst             (sys_rst),
      .cfg_addr            (cfg_addr),
      .cfg_rd              (cfg_rd),
      .cfg_wr              (cfg_wr),
      .cfg_wdata           (cfg_wdata),
      .cfg_rdata           (cfg_rdata),
      .error_event         (error_event),
      .error_command       (error_command),
      .func1_serr_enable   (func1_serr_enable),
      .func1_serr_event    (func1_serr_event),
      .hub_msg_ready       (hub_msg_ready),
      .hub_link_serr_msg   (hub_link_serr_msg),
      .serr_reported       (serr_reported),
      .master_enable       (master_enable),
      .memory_space_enable (memory_space_enable),
      .hub_serr_active     (hub_serr_active)
   );
   hbc_hub_model hub (
      .mclk  (mclk),
      .stall (stall),
      .msg   (hub_link_serr_msg),
      .ready (hub_msg_ready),
      .msgs  (msgs)
   );
   initial forever #10 mclk = ~mclk;
   task chk(input hbc_word_t got, input hbc_word_t exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input hbc_addr_t a, input hbc_word_t d);
      @(negedge mclk);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr = w;
      cfg_rd = !w;
      @(negedge mclk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      @(negedge mclk);
   endtask
   task err(input logic [3:0] e);
      error_event = e;
      @(negedge mclk);
      error_event = 4'h0;
   endtask
   task t_regs;
      acc(1'b0, 8'h04, 16'h0000);
      chk(cfg_rdata, 16'h0006);
      acc(1'b0, 8'h10, 16'h0000);
      chk(cfg_rdata, 16'h0000);
      acc(1'b1, 8'h04, 16'hFFFF);
      acc(1'b0, 8'h04, 16'h0000);
      chk(cfg_rdata, 16'h0106);
      acc(1'b1, 8'h02, 16'h0000);
      acc(1'b0, 8'h02, 16'h0000);
      chk(cfg_rdata, FUNC_ID);
      chk({14'h0, master_enable, memory_space_enable}, 16'h0003);
   endtask
   task t_serr;
      stall = 1'b1;
      acc(1'b1, 8'h04, 16'h0000);
      err(4'h1);
      chk(16'(serr_reported), 16'h0000);
      acc(1'b1, 8'h04, 16'h0100);
      error_command = 4'hD;
      err(4'h2);
      chk(16'(serr_reported), 16'h0000);
      error_command = 4'hF;
      err(4'h2);
      chk(16'(serr_reported), 16'h0001);
      acc(1'b0, 8'h06, 16'h0000);
      chk(cfg_rdata, 16'h4090);
      chk(16'(msgs), 16'h0000);
      stall = 1'b0;
      repeat (4) @(negedge mclk);
      chk(16'(msgs), 16'h0001);
      acc(1'b1, 8'h06, 16'h4000);
      acc(1'b0, 8'h06, 16'h0000);
      chk(cfg_rdata, 16'h0090);
      acc(1'b1, 8'h04, 16'h0000);
      func1_serr_enable = 1'b1;
      err(4'h4);
      chk(16'(serr_reported), 16'h0000);
      func1_serr_event = 1'b1;
      @(negedge mclk);
      func1_serr_event = 1'b0;
      repeat (4) @(negedge mclk);
      chk({15'h0, hub_serr_active}, 16'h0001);
      chk(16'(msgs), 16'h0002);
   endtask
   task t_setwin;
      acc(1'b1, 8'h04, 16'h0100);
      cfg_addr = 8'h06;
      cfg_wdata = 16'h4000;
      cfg_wr = 1'b1;
      error_event = 4'h1;
      @(negedge mclk);
      cfg_wr = 1'b0;
      error_event = 4'h0;
      acc(1'b0, 8'h06, 16'h0000);
      chk(cfg_rdata, 16'h4090);
   endtask
   task t_reset;
      func1_serr_enable = 1'b0;
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      chk({14'h0, master_enable, memory_space_enable}, 16'h0000);
      sys_rst = 1'b0;
      acc(1'b0, 8'h04, 16'h0000);
      chk(cfg_rdata, 16'h0006);
      acc(1'b0, 8'h06, 16'h0000);
      chk(cfg_rdata, 16'h0090);
   endtask
   task finish_test;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 0;
      t_regs;
      t_serr;
      t_setwin;
      t_reset;
      finish_test;
   end
   initial begin
      #100us;
      errors++;
      finish_test;
   end
endmodule
`default_nettype wire
